// [dv/ramp_flags_sva.sv]
`timescale 1ns/1ps
module ramp_flags_sva (
    input wire ref_clk,
    input wire rstn,
    input wire stallTrigger,
    input wire moveLeft,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_awready,
    input wire stallHold,
    input wire stopHoldR,
    input wire stopHoldL,
    input wire irq
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    // A write answer still waiting, and a read address taken.
    sequence bPend; s_axi_bvalid && !s_axi_bready; endsequence
    sequence rdTaken; s_axi_arvalid && s_axi_arready; endsequence
    chk_stall_set: assert property (
        stallTrigger |=> stallHold) else $error("stall flag not set");
    chk_stall_kept: assert property (
        stallHold && !stallTrigger |=> stallHold || $rose(s_axi_bvalid))
        else $error("stall flag lost");
    chk_stop_kept: assert property (
        stopHoldR && !moveLeft |=>
        stopHoldR || s_axi_bvalid || $past(s_axi_bvalid))
        else $error("stop flag lost");
    chk_irq_events: assert property (
        stallHold || stopHoldR || stopHoldL |-> irq)
        else $error("event without interrupt");
    chk_bresp_hold: assert property (bPend |=> s_axi_bvalid)
        else $error("write answer dropped");
    chk_rd_answer: assert property (rdTaken |=> s_axi_rvalid && !s_axi_arready)
        else $error("read answer late");
    chk_rresp_hold: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
        else $error("read answer dropped");
    chk_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready)
        else $error("address taken while answering");
endmodule // ramp_flags_sva

bind ramp_event_status_flags ramp_flags_sva chk (.*);

// [dv/tb_top.sv]
`timescale 1ns/1ps
`include "ramp_status_map.vh"
module tb_top;
    reg         ref_clk, rstn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    reg         s_axi_arvalid, s_axi_rready, stallTrigger, stopSwitchR;
    reg         stopSwitchL, latchEventR, latchEventL, refSwitchR, moveLeft;
    reg         moveRight, movingRight, movingLeft;
    reg  [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
    reg  [31:0] s_axi_wdata, r, acc;
    wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    wire        s_axi_rvalid, stallHold, stopHoldR, stopHoldL, irq;
    wire [1:0]  s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    integer     failures, check_count, seed, i;

    ramp_event_status_flags dut (.*);

    // Expected status word for flags given as stall,stopR,stopL,latR,latL.
    function [31:0] st(input [6:0] v);
        st = {25'h0, v[6:2], 2'h0};
    endfunction

    task check(input [31:0] got, input [31:0] exp);
        begin
            check_count = check_count + 1;
            if (got !== exp)
                $display("wrong value at %0t: %h vs %h", $time, got, exp);
            if (got !== exp)
                failures = failures + 1;
        end
    endtask

    // One register access; ready and answers are read before the edge.
    task bus(input wr, input [3:0] a, input [31:0] d, input [31:0] e);
        reg       tA, tW;
        reg [1:0] q;
        begin
            s_axi_awaddr <= a;
            s_axi_araddr <= a;
            s_axi_wdata <= d;
            {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{wr}};
            {s_axi_arvalid, s_axi_rready} <= {2{!wr}};
            @(negedge ref_clk);
            while (!(s_axi_bvalid || s_axi_rvalid)) begin
                tA = wr ? s_axi_awready : s_axi_arready;
                tW = s_axi_wready;
                @(posedge ref_clk);
                if (tA) {s_axi_awvalid, s_axi_arvalid} <= 2'h0;
                if (tW) s_axi_wvalid <= 1'h0;
                @(negedge ref_clk);
            end
            @(posedge ref_clk);
            r = wr ? {30'h0, s_axi_bresp} : s_axi_rdata;
            q = s_axi_rresp;
            {s_axi_bready, s_axi_rready} <= 2'h0;
            check(r, e);
            if (!wr)
                check({30'h0, q}, a[1:0] ? `RESP_SLVERR : `RESP_OKAY);
            @(posedge ref_clk);
        end
    endtask

    // Pulse events and moves for one cycle.
    task kick(input [6:0] v);
        begin
            {stallTrigger, stopSwitchR, stopSwitchL, latchEventR,
             latchEventL, moveLeft, moveRight} <= v;
            @(posedge ref_clk);
            {stallTrigger, stopSwitchR, stopSwitchL, latchEventR,
             latchEventL, moveLeft, moveRight} <= 7'h00;
            @(posedge ref_clk);
        end
    endtask

    task close_out;
        begin
            $display("checks %0d failures %0d", check_count, failures);
            if (failures == 0 && check_count > 0)
                $display("bench passed");
            else
                $display("bench failed");
            $finish;
        end
    endtask

    // Free-running clock.
    initial begin
        ref_clk = 1'h0;
        forever #25 ref_clk = ~ref_clk;
    end

    // Watchdog cuts a hang short.
    initial begin
        #1000000;
        failures = failures + 1;
        close_out;
    end

    // Main sequence of tests.
    initial begin
        {rstn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid,
         s_axi_rready, stallTrigger, stopSwitchR, stopSwitchL, latchEventR,
         latchEventL, refSwitchR, moveLeft, moveRight, movingRight,
         movingLeft, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 0;
        s_axi_wstrb = 4'hF;
        {failures, check_count, seed} = {32'h0, 32'h0, 32'h32};
        repeat (5) @(posedge ref_clk);
        rstn <= 1'h1;
        @(posedge ref_clk);
        bus(0, `ADDR_STATUS, 0, 0);
        bus(0, `ADDR_CONTROL, 0, `CONTROL_RESET);
        bus(0, `ADDR_IRQ_EN, 0, `IRQ_EN_RESET);
        bus(1, 4'h6, 0, `RESP_SLVERR);
        bus(0, 4'h6, 0, 0);
        s_axi_wstrb <= 4'hE;
        bus(1, `ADDR_CONTROL, 0, `RESP_OKAY);
        s_axi_wstrb <= 4'hF;
        bus(0, `ADDR_CONTROL, 0, `CONTROL_RESET);
        $display("test reset done");
        kick(7'h40);
        check({stallHold, irq}, 2'h3);
        bus(1, `ADDR_STATUS, 0, `RESP_OKAY);
        check(stallHold, 1);
        bus(1, `ADDR_STATUS, 32'h40, `RESP_OKAY);
        check({stallHold, irq}, 0);
        $display("test stall done");
        kick(7'h30);
        bus(0, `ADDR_STATUS, 0, st(7'h30));
        kick(7'h02);
        check({stopHoldR, stopHoldL}, 2'h1);
        kick(7'h01);
        check(stopHoldL, 0);
        kick(7'h20);
        bus(1, `ADDR_CONTROL, 32'h17, `RESP_OKAY);
        check(stopHoldR, 0);
        bus(1, `ADDR_CONTROL, 32'h0F, `RESP_OKAY);
        movingRight <= 1'h1;
        kick(7'h22);
        kick(7'h02);
        check(stopHoldR, 1);
        movingRight <= 1'h0;
        kick(7'h02);
        check(stopHoldR, 0);
        kick(7'h10);
        bus(1, `ADDR_CONTROL, 32'h05, `RESP_OKAY);
        check(stopHoldL, 0);
        bus(1, `ADDR_CONTROL, 32'h03, `RESP_OKAY);
        kick(7'h20);
        check(stopHoldR, 0);
        bus(1, `ADDR_CONTROL, 32'h07, `RESP_OKAY);
        $display("test stop done");
        kick(7'h0C);
        check(irq, 0);
        bus(1, `ADDR_IRQ_EN, 32'h7C, `RESP_OKAY);
        check(irq, 1);
        bus(1, `ADDR_IRQ_EN, 32'h70, `RESP_OKAY);
        check(irq, 0);
        bus(0, `ADDR_STATUS, 0, st(7'h0C));
        bus(1, `ADDR_IRQ_CLR, 32'h0C, `RESP_OKAY);
        bus(0, `ADDR_STATUS, 0, 0);
        refSwitchR <= 1'h1;
        repeat (6) @(posedge ref_clk);
        bus(0, `ADDR_STATUS, 0, 32'h2);
        refSwitchR <= 1'h0;
        repeat (6) @(posedge ref_clk);
        $display("test latch done");
        acc = 0;
        for (i = 0; i < 32; i = i + 1) begin
            r = $random(seed);
            kick({r[4:0], 2'h0});
            acc = acc | {r[4:0], 2'h0};
            if (i % 8 == 7) begin
                bus(0, `ADDR_STATUS, 0, st(acc[6:0]));
                bus(1, `ADDR_STATUS, 32'h7F, `RESP_OKAY);
                acc = 0;
            end
        end
        $display("test random done");
        close_out;
    end
endmodule // tb_top

// [logic/ramp_event_status_flags.v]
// The address map and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
`include "ramp_status_map.vh"

module ramp_event_status_flags (
    // Clock and asynchronous active-low reset.
    input  wire        ref_clk,
    input  wire        rstn,
    // Register bus, write address and write data channels.
    input  wire [3:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    // Write response channel.
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    // Read address and read data channels.
    input  wire [3:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // Event sources from the ramp and switch logic on this clock.
    input  wire        stallTrigger,
    input  wire        stopSwitchR,
    input  wire        stopSwitchL,
    input  wire        latchEventR,
    input  wire        latchEventL,
    // Right reference switch pin, asynchronous to the clock.
    input  wire        refSwitchR,
    // Commanded and actual direction of motion.
    input  wire        moveLeft,
    input  wire        moveRight,
    input  wire        movingRight,
    input  wire        movingLeft,
    // Holds back to the ramp, and the interrupt pin.
    output wire        stallHold,
    output wire        stopHoldR,
    output wire        stopHoldL,
    output wire        irq
);

    // Flag, control and interrupt enable registers.
    reg  [6:0]  status;
    reg  [4:0]  control;
    reg  [6:0]  irqEnable;

    // Write capture, so that address and data may come in either order.
    reg  [3:0]  awAddr;
    reg  [31:0] wData;
    reg  [3:0]  wStrb;
    reg         awHeld;
    reg         wHeld;

    // Reference switch synchroniser and its accepted level.
    reg  [2:0]  swSync;
    reg         swState;

    // Combinational next values.
    reg  [6:0]  next_status;
    reg  [31:0] readWord;

    // Decoded strobes and control fields.
    wire        doWrite;
    wire        clrStall;
    wire [6:0]  clrMask;
    wire        wrStatus;
    wire        wrClear;
    wire        holdMode;
    wire        softStop;
    wire        stopFunc;
    wire        enR;
    wire        enL;
    wire        keepR;
    wire        keepL;

    // Address and data are each taken once, and only while no answer waits.
    // Holding both halves lets the master offer them in either order.
    // A new write is refused until the previous answer has been taken.
    assign s_axi_awready = !awHeld && !s_axi_bvalid;
    assign s_axi_wready  = !wHeld && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign doWrite       = awHeld && wHeld && !s_axi_bvalid;

    // Control fields; a stop switch only counts while the stop function is on.
    assign holdMode = control[`CTL_HOLD_MODE];
    assign softStop = control[`CTL_SOFT_STOP];
    assign stopFunc = control[`CTL_STOP_FUNC];
    assign enR      = stopFunc && control[`CTL_STOP_R_EN];
    assign enL      = stopFunc && control[`CTL_STOP_L_EN];

    // Write one to the status word or the clear word clears flags.
    // Only the low byte lane carries flags, so strobe bit 0 gates the clear.
    assign wrStatus = doWrite && wStrb[0] && (awAddr == `ADDR_STATUS);
    assign wrClear  = doWrite && wStrb[0] && (awAddr == `ADDR_IRQ_CLR);
    assign clrMask  = (wrStatus || wrClear) ? wData[6:0] : 7'h00;
    assign clrStall = clrMask[`BIT_STALL];

    // In gradual stop a stop event persists while motion toward the switch.
    // Outside gradual stop the motor halts at once, so nothing holds it.
    // soft stop persistence
    assign keepR = softStop && movingRight;
    assign keepL = softStop && movingLeft;

    // Flag update: set wins over clear, removal actions drop stop events.
    // The order of the steps below matters: clears come first, removals
    // next and sets last, so an event that arrives in the cycle of a clear
    // or of a removal is never lost, except a stop event in hold mode, which the set masks.
    always @* begin
        next_status = status;

        // sticky flags
        // Writing one to a bit clears it; writing zero leaves it.
        next_status = next_status & ~clrMask;

        // hold or reverse removal
        // A move to the left leaves the right switch behind.
        if ((holdMode || moveLeft) && !keepR) begin
            next_status[`BIT_STOP_R] = 1'b0;
        end

        // left removal mirrors
        // A move to the right leaves the left switch behind.
        if ((holdMode || moveRight) && !keepL) begin
            next_status[`BIT_STOP_L] = 1'b0;
        end

        // disable clears stop
        // This acts in every cycle while disabled, not only on the change.
        if (!enR) begin
            next_status[`BIT_STOP_R] = 1'b0;
        end
        if (!enL) begin
            next_status[`BIT_STOP_L] = 1'b0;
        end

        // stall sets flag
        // A trigger held high sets the flag again in every cycle.
        if (stallTrigger) begin
            next_status[`BIT_STALL] = 1'b1;
        end

        // right stop set
        // Hold mode masks new stop events as well as removing old ones.
        if (enR && stopSwitchR && !holdMode) begin
            next_status[`BIT_STOP_R] = 1'b1;
        end

        if (enL && stopSwitchL && !holdMode) begin
            next_status[`BIT_STOP_L] = 1'b1;
        end

        // right latch ready
        // Latch pulses come from the position logic on this clock.
        if (latchEventR) begin
            next_status[`BIT_LATCH_R] = 1'b1;
        end

        if (latchEventL) begin
            next_status[`BIT_LATCH_L] = 1'b1;
        end

        // live switch state
        // The synchronised level is reported, never the raw pin.
        next_status[`BIT_SW_R] = swState;

        // Bit 0 is unused and always reads zero.
        next_status[0] = 1'b0;
    end

    // The switch pin passes three flops, a change counts when two agree.
    // The first flop may go metastable; only its neighbour reads it.
    // Two agreeing samples also filter a single-cycle glitch on the pin.
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            swSync  <= 3'h0;
            swState <= 1'b0;
        end else begin
            swSync <= {swSync[1:0], refSwitchR};
            if (swSync[1] == swSync[2]) begin
                swState <= swSync[2];
            end
        end
    end

    // Status flags.
    // Clearing and setting are decided in the next value above.
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            status <= 7'h00;
        end else begin
            status <= next_status;
        end
    end

    // The stall hold lasts exactly as long as the stall flag.
    // The stop holds likewise follow their flags.
    // Clearing a flag therefore lets the ramp move on at once.
    // clear releases stall
    assign stallHold = status[`BIT_STALL];
    assign stopHoldR = status[`BIT_STOP_R];
    assign stopHoldL = status[`BIT_STOP_L];

    // Interrupt is high while any enabled flag is set.
    // Bit 1 tracks the live switch and only raises irq if enabled.
    // events ORed to irq
    assign irq = |(status & irqEnable);

    // Write channel capture and control registers.
    // The write takes effect at the same edge at which bvalid rises.
    // Unmapped offsets answer with an error and change nothing.
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            awHeld       <= 1'b0;
            wHeld        <= 1'b0;
            awAddr       <= 4'h0;
            wData        <= 32'h00000000;
            wStrb        <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `RESP_OKAY;
            control      <= `CONTROL_RESET;
            irqEnable    <= `IRQ_EN_RESET;
        end else begin
            // Capture the address as soon as it is offered.
            if (s_axi_awvalid && s_axi_awready) begin
                awHeld <= 1'b1;
                awAddr <= s_axi_awaddr;
            end
            // Capture data and strobes independently of the address.
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld <= 1'b1;
                wData <= s_axi_wdata;
                wStrb <= s_axi_wstrb;
            end
            if (doWrite) begin
                awHeld       <= 1'b0;
                wHeld        <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= `RESP_OKAY;
                case (awAddr)
                    `ADDR_STATUS, `ADDR_IRQ_CLR: begin
                        // Flag clears are handled in the next status value.
                    end
                    `ADDR_CONTROL: begin
                        if (wStrb[0]) begin
                            control <= wData[4:0];
                        end
                    end
                    `ADDR_IRQ_EN: begin
                        if (wStrb[0]) begin
                            irqEnable <= wData[6:0];
                        end
                    end
                    default: begin
                        s_axi_bresp <= `RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_bvalid && s_axi_bready) begin
                // The answer stands until the master takes it.
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Read word selection; the clear register reads as zero.
    // The address is decoded while arvalid stands, before it is taken.
    always @* begin
        case (s_axi_araddr)
            `ADDR_STATUS:  readWord = {25'h0000000, status};
            `ADDR_CONTROL: readWord = {27'h0000000, control};
            `ADDR_IRQ_EN:  readWord = {25'h0000000, irqEnable};
            default:       readWord = 32'h00000000;
        endcase
    end

    // Read channel answers one cycle after the address is taken.
    // No new address is taken while an answer waits for rready.
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= `RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= readWord;
            // The response is decoded from the same address.
            if (s_axi_araddr == `ADDR_STATUS || s_axi_araddr == `ADDR_CONTROL
                || s_axi_araddr == `ADDR_IRQ_EN
                || s_axi_araddr == `ADDR_IRQ_CLR) begin
                s_axi_rresp <= `RESP_OKAY;
            end else begin
                s_axi_rresp <= `RESP_SLVERR;
            end
        end else if (s_axi_rvalid && s_axi_rready) begin
            // Release once the master has taken the answer.
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule // ramp_event_status_flags

// [logic/ramp_status_map.vh]
// What this block does
// - A load detection stall trigger sets the stall flag at bit 6.
// - Writing one clears the stall flag and its interrupt; zero keeps it.
// - Clearing the stall flag releases the stall hold on motion.
// - Stall, right and left stop event flags are ORed onto the interrupt.
// - An enabled right stop switch stop sets the right stop flag, bit 5.
// - Hold mode or a move away from the switch removes a stop event.
// - In gradual stop a stop event stays until motion toward it ends.
// - Disabling the switch or the stop function clears its stop event.
// - An enabled left stop switch sets the left stop flag, as on the right.
// - A right position latch sets the right latch flag at bit 3, W1C.
// - A left position latch sets the left latch flag at bit 2, W1C.
// - Bit 1 reads the live right reference switch, one when active.
`ifndef RAMP_STATUS_MAP_VH
`define RAMP_STATUS_MAP_VH

// Byte addresses of the registers.
`define ADDR_STATUS    4'h0
`define ADDR_CONTROL   4'h4
`define ADDR_IRQ_EN    4'h8
`define ADDR_IRQ_CLR   4'hC

// Status bit positions.
`define BIT_STALL      6
`define BIT_STOP_R     5
`define BIT_STOP_L     4
`define BIT_LATCH_R    3
`define BIT_LATCH_L    2
`define BIT_SW_R       1

// Control bit positions.
`define CTL_STOP_R_EN  0
`define CTL_STOP_L_EN  1
`define CTL_STOP_FUNC  2
`define CTL_SOFT_STOP  3
`define CTL_HOLD_MODE  4

// Reset values.
`define CONTROL_RESET  5'h07
`define IRQ_EN_RESET   7'h70

// AXI responses.
`define RESP_OKAY      2'h0
`define RESP_SLVERR    2'h2

`endif
